// ### afs_params.svh
// Overview of operation
// - Demand missing flag on timeout, slow update rate, or value 64256..65535.
// - While demand missing, hold network demand at last commanded value.
// - Network fault reaction selectable; a shutdown reaction becomes alarm with redundant demand sources.
// - Stop command goes limp via shutdown action; setpoint mode goes limp at once.
// - Network stop honoured only with network demand and second legacy mode.
// - Active stop asserts stop indication plus common alarm or shutdown.
// - Bus error-passive raises bus fault and holds demand at last value.
// - Bus fault clearing in non-latching mode resumes normal demand handling.
// - Address claim failure raises fault and forces network demand to zero.
// - Address claim retried only after name settings change or power cycle.
// - Electronics overtemp clear delay is three times the set delay.
// - Above 100 C for 5 s derates current; restore after 5 s absent.
// - Above 140 C goes limp unlatched; resume after 5 s below 140 C.
// - Thermal limp enabled only when current derate fault is enabled.
// - Both temperature sensors out of range oppositely flags fault, substitutes 25 C.
// - Feedback sensor fault latches after 10 ms, only without sensor fault.
// - Feedback fault cuts current, or in setpoint mode drives to hard stop.
// - Bad stored data latches limp shutdown, cleared by reset or power cycle.
// - Supply rail fault latches after 50 ms out of range.
// - Abnormal processor restart latches a fault until reset or power cycle.
// - Power-on indication raised after power-up, reaction configurable.
// - All demands lost only when every configured demand source has failed.
`ifndef AFS_PARAMS_SVH
`define AFS_PARAMS_SVH
// APB register offsets
`define AFS_CTRL_OFS      12'h000
`define AFS_CFG_OFS       12'h004
`define AFS_INPUT_OFS     12'h008
`define AFS_DELAY_OFS     12'h00C
`define AFS_STATUS_OFS    12'h010
`define AFS_ACTION_OFS    12'h014
`define AFS_DEMAND_OFS    12'h018
`define AFS_TEMP_OFS      12'h01C
// Fixed figures
`define AFS_CLK_HZ        10000000
`define AFS_DMD_ERR_LO    16'hFB00
`define AFS_TEMP_DERATE   9'sd100
`define AFS_TEMP_LIMP     9'sd140
`define AFS_TEMP_LOW      -9'sd45
`define AFS_TEMP_DEFAULT  9'sd25
`define AFS_THERMAL_S     5
`define AFS_FEEDBACK_MS   10
`define AFS_RAIL_MS       50
`define AFS_HALF_POS      16'h8000
`define AFS_CLR_FACTOR    3
// Reaction codes
`define AFS_REACT_NONE    2'h0
`define AFS_REACT_ALARM   2'h1
`define AFS_REACT_SHUT    2'h2
`endif

// ### afs_pkg.sv
package afs_pkg;
  typedef enum logic [2:0] {
    AFS_ACT_LIMP     = 3'b001,
    AFS_ACT_POS_LIMP = 3'b010,
    AFS_ACT_SETPOINT = 3'b100
  } afs_action_t;
  typedef enum logic [3:0] {
    AFS_DRV_RUN  = 4'b0001,
    AFS_DRV_LIMP = 4'b0010,
    AFS_DRV_MIN  = 4'b0100,
    AFS_DRV_MAX  = 4'b1000
  } afs_drive_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } afs_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } afs_apb_rsp_t;
  // Sampled raw condition inputs
  typedef struct packed {
    logic       bus_passive;
    logic       claim_fail;
    logic       name_change;
    logic       discrete_run;
    logic       net_stop_cmd;
    logic       feedback_bad;
    logic       nv_bad;
    logic       rail_bad;
    logic       wd_reset;
  } afs_cond_t;
  typedef struct packed {
    logic [15:0] demand_held;
    logic        demand_valid;
    logic [31:0] timeout_cnt;
    logic [31:0] rate_cnt;
    logic [31:0] ot_cnt;
    logic [31:0] der_cnt;
    logic [31:0] limp_cnt;
    logic [31:0] fb_cnt;
    logic [31:0] rail_cnt;
    logic        missing;
    logic        bus_err;
    logic        claim;
    logic        claim_tried;
    logic        overtemp;
    logic        derate;
    logic        limp;
    logic        tsens;
    logic        feedback;
    logic        nvfail;
    logic        rail;
    logic        wdog;
    logic        power_on;
    logic        net_stop;
    logic        disc_stop;
    logic        stop_ind;
    logic        all_lost;
    logic [8:0]  temp_used;
    afs_drive_t  drive;
    logic        alarm;
    logic        shut;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] delay;
    logic [31:0] prdata;
    logic        pslverr;
    logic        pready;
  } afs_state_t;
endpackage

// ### afs_supervisor.sv
`include "afs_params.svh"
module afs_supervisor
  import afs_pkg::*;
#(
  parameter int unsigned FEEDBACK_CYC = `AFS_FEEDBACK_MS * (`AFS_CLK_HZ / 1000),
  parameter int unsigned RAIL_CYC     = `AFS_RAIL_MS * (`AFS_CLK_HZ / 1000),
  parameter int unsigned THERMAL_CYC  = `AFS_THERMAL_S * `AFS_CLK_HZ
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire afs_apb_req_t i_apb,
  output afs_apb_rsp_t      o_apb,
  input  wire logic         i_demand_strobe,
  input  wire logic [15:0]  i_demand_value,
  input  wire logic         i_bus_passive,
  input  wire logic         i_claim_fail,
  input  wire logic         i_name_change,
  input  wire logic         i_discrete_run,
  input  wire logic         i_net_stop_cmd,
  input  wire logic         i_reset_cmd,
  input  wire logic signed [8:0] i_temp_a,
  input  wire logic signed [8:0] i_temp_b,
  input  wire logic         i_feedback_bad,
  input  wire logic         i_nv_bad,
  input  wire logic         i_rail_bad,
  input  wire logic         i_wd_reset,
  output logic [15:0]       o_net_demand,
  output afs_drive_t        o_drive,
  output logic              o_current_derate,
  output logic              o_alarm,
  output logic              o_shutdown,
  output logic              o_stop_indication
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  afs_cond_t  s1_reg, s2_reg, s3_reg;
  afs_cond_t  cond_raw;
  assign cond_raw = '{i_bus_passive, i_claim_fail, i_name_change, i_discrete_run,
                      i_net_stop_cmd, i_feedback_bad, i_nv_bad, i_rail_bad, i_wd_reset};
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= cond_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  afs_cond_t c;
  afs_cond_t c_hold_reg;
  // Filtered value moves only on agreement, so single glitches are dropped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c_hold_reg <= '0;
    end else begin
      c_hold_reg <= c;
    end
  end
  always_comb begin
    for (int i = 0; i < $bits(afs_cond_t); i++) begin
      c[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : c_hold_reg[i];
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Persistence counter: counts while cond, returns next count saturating at lim
  function automatic logic [31:0] persist(input logic cnd, input logic [31:0] cnt, input logic [31:0] lim);
    persist = !cnd ? 32'h0 : (cnt >= lim) ? lim : cnt + 32'h1;
  endfunction
  function automatic logic [1:0] react(input logic [31:0] cfg, input int sh);
    logic [1:0] r;
    r = cfg[sh +: 2];
    react = (cfg[3] && r == `AFS_REACT_SHUT) ? `AFS_REACT_ALARM : r;
  endfunction

  afs_state_t st_reg, st_next;
  logic apb_wr, apb_rd;
  logic [31:0] ot_set, ot_clr;
  logic signed [8:0] ta, tb, tused;
  logic a_hi, a_lo, b_hi, b_lo, dmd_err, stop_any, limp_req;
  afs_action_t act;

  // ****************************************
  // Next state
  // ****************************************
  // CFG bits: 0 net demand used, 1 second legacy mode, 2 non-latching,
  // 3 redundant sources, 4 overtemp en, 5 derate en, 6 sensor en, 7 rail en,
  // 8 watchdog en, 9 power-on en, 10 stop-as-shutdown, 12:11 action,
  // 13 backup source used, 14 backup failed, 15 discrete stop used,
  // 17:16 missing react, 19:18 bus react, 21:20 claim react, 23:22 others
  always_comb begin
    st_next  = st_reg;
    apb_wr   = i_apb.psel && i_apb.penable && i_apb.pwrite;
    apb_rd   = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
    ta       = i_temp_a;
    tb       = i_temp_b;
    act      = afs_action_t'(3'(1 << st_reg.cfg[12:11]));
    ot_set   = st_reg.delay;
    ot_clr   = 32'(`AFS_CLR_FACTOR * st_reg.delay);
    a_hi     = ta > `AFS_TEMP_LIMP;
    a_lo     = ta < `AFS_TEMP_LOW;
    b_hi     = tb > `AFS_TEMP_LIMP;
    b_lo     = tb < `AFS_TEMP_LOW;
    dmd_err  = i_demand_value >= `AFS_DMD_ERR_LO;
    // Sensor fault on opposite out-of-range, then default temperature
    st_next.tsens = st_reg.cfg[6] && ((a_hi && b_lo) || (a_lo && b_hi));
    tused = st_next.tsens ? `AFS_TEMP_DEFAULT : ((ta > tb) ? ta : tb);
    st_next.temp_used = tused;
    // Demand timeout and update-rate monitors; delay[15:0] timeout, [31:16] rate
    st_next.timeout_cnt = i_demand_strobe ? 32'h0 : persist(1'b1, st_reg.timeout_cnt, 32'hFFFF_FFFF);
    st_next.rate_cnt    = i_demand_strobe ? 32'h0 : persist(1'b1, st_reg.rate_cnt, 32'hFFFF_FFFF);
    // Missing on timeout, slow rate or error-range value
    st_next.missing = st_reg.cfg[0] && ((st_reg.timeout_cnt > {16'h0, st_reg.delay[15:0]}) ||
                      (st_reg.rate_cnt > {16'h0, st_reg.delay[31:16]}) ||
                      (i_demand_strobe ? dmd_err : (st_reg.missing && !i_demand_strobe)));
    // Bus fault: hold while error-passive; latching unless non-latching set
    st_next.bus_err = st_reg.cfg[0] && (c.bus_passive || (st_reg.bus_err && !st_reg.cfg[2] && !i_reset_cmd));
    // Claim tried once per name setting or power cycle
    if (c.name_change) begin
      st_next.claim_tried = 1'b0;
      st_next.claim       = 1'b0;
    end else if (!st_reg.claim_tried && st_reg.cfg[0]) begin
      st_next.claim_tried = 1'b1;
      st_next.claim       = c.claim_fail;
    end
    // Held demand: freeze on faults, zero on claim fault
    if (i_demand_strobe && !dmd_err && !st_next.missing && !st_next.bus_err) begin
      st_next.demand_held = i_demand_value;
    end
    if (st_next.claim) begin
      st_next.demand_held = 16'h0;
    end
    // Overtemp: set after delay, clear after three delays
    st_next.ot_cnt = persist(st_reg.overtemp ? tused <= `AFS_TEMP_DERATE : tused > `AFS_TEMP_DERATE,
                             st_reg.ot_cnt, st_reg.overtemp ? ot_clr : ot_set);
    if (st_reg.cfg[4] && st_next.ot_cnt >= (st_reg.overtemp ? ot_clr : ot_set)) begin
      st_next.overtemp = !st_reg.overtemp;
      st_next.ot_cnt   = 32'h0;
    end
    // Derate with 5 s on and off delays
    st_next.der_cnt = persist(st_reg.derate ? tused <= `AFS_TEMP_DERATE : tused > `AFS_TEMP_DERATE,
                              st_reg.der_cnt, THERMAL_CYC);
    if (st_next.der_cnt >= THERMAL_CYC) begin
      st_next.derate  = !st_reg.derate;
      st_next.der_cnt = 32'h0;
    end
    // Thermal limp, unlatched, only with derating enabled
    st_next.limp_cnt = persist(st_reg.limp ? tused < `AFS_TEMP_LIMP : tused > `AFS_TEMP_LIMP,
                               st_reg.limp_cnt, THERMAL_CYC);
    if (st_next.limp_cnt >= THERMAL_CYC) begin
      st_next.limp     = !st_reg.limp && st_reg.cfg[5];
      st_next.limp_cnt = 32'h0;
    end
    if (!st_reg.cfg[5]) begin
      st_next.limp = 1'b0;
    end
    // Latched internal faults; reset command clears if cause gone
    st_next.fb_cnt   = persist(c.feedback_bad && !st_reg.tsens, st_reg.fb_cnt, FEEDBACK_CYC);
    st_next.rail_cnt = persist(c.rail_bad && st_reg.cfg[7], st_reg.rail_cnt, RAIL_CYC);
    st_next.feedback = (st_next.fb_cnt >= FEEDBACK_CYC) ||
                       (st_reg.feedback && !(i_reset_cmd && !c.feedback_bad));
    st_next.nvfail   = c.nv_bad || (st_reg.nvfail && !i_reset_cmd);
    st_next.rail     = (st_next.rail_cnt >= RAIL_CYC) ||
                       (st_reg.rail && !(i_reset_cmd && !c.rail_bad));
    st_next.wdog     = (st_reg.cfg[8] && c.wd_reset) || (st_reg.wdog && !i_reset_cmd);
    st_next.power_on = st_reg.power_on && !i_reset_cmd;
    // Stops
    st_next.net_stop  = st_reg.cfg[0] && st_reg.cfg[1] && c.net_stop_cmd;
    st_next.disc_stop = st_reg.cfg[15] && !c.discrete_run;
    st_next.all_lost  = st_next.missing && (!st_reg.cfg[13] || st_reg.cfg[14]);
    stop_any = st_next.net_stop || st_next.disc_stop;
    limp_req = stop_any || st_next.nvfail || st_next.limp;
    // Registered so the stop output leaves a flip-flop with alarm and shutdown
    st_next.stop_ind = stop_any;
    // Drive decision
    if (st_next.feedback && act == AFS_ACT_SETPOINT) begin
      st_next.drive = (st_reg.ctrl[15:0] < `AFS_HALF_POS) ? AFS_DRV_MIN : AFS_DRV_MAX;
    end else if (st_next.feedback || limp_req) begin
      st_next.drive = AFS_DRV_LIMP;
    end else begin
      st_next.drive = AFS_DRV_RUN;
    end
    // Common outputs; stop indicated by alarm or shutdown per config
    st_next.shut  = (stop_any && st_reg.cfg[10]) || st_next.feedback || st_next.nvfail || st_next.limp ||
                    (st_next.missing && react(st_reg.cfg, 16) == `AFS_REACT_SHUT) ||
                    (st_next.bus_err && react(st_reg.cfg, 18) == `AFS_REACT_SHUT) ||
                    (st_next.claim && react(st_reg.cfg, 20) == `AFS_REACT_SHUT) ||
                    ((st_next.overtemp || st_next.rail || st_next.wdog || st_next.power_on || st_next.all_lost)
                     && st_reg.cfg[23:22] == `AFS_REACT_SHUT);
    st_next.alarm = (stop_any && !st_reg.cfg[10]) || st_next.derate || st_next.tsens ||
                    (st_next.missing && react(st_reg.cfg, 16) == `AFS_REACT_ALARM) ||
                    (st_next.bus_err && react(st_reg.cfg, 18) == `AFS_REACT_ALARM) ||
                    (st_next.claim && react(st_reg.cfg, 20) == `AFS_REACT_ALARM) ||
                    ((st_next.overtemp || st_next.rail || st_next.wdog || st_next.power_on || st_next.all_lost)
                     && st_reg.cfg[23:22] == `AFS_REACT_ALARM);
    // APB: zero wait, error on unmapped reads only
    st_next.pready  = i_apb.psel && !i_apb.penable;
    st_next.pslverr = 1'b0;
    if (apb_wr) begin
      case (i_apb.paddr)
        `AFS_CTRL_OFS:  st_next.ctrl  = i_apb.pwdata;
        `AFS_CFG_OFS:   st_next.cfg   = i_apb.pwdata;
        `AFS_DELAY_OFS: st_next.delay = i_apb.pwdata;
        default:        st_next.pslverr = 1'b0;
      endcase
    end
    if (apb_rd) begin
      case (i_apb.paddr)
        `AFS_CTRL_OFS:   st_next.prdata = st_reg.ctrl;
        `AFS_CFG_OFS:    st_next.prdata = st_reg.cfg;
        `AFS_INPUT_OFS:  st_next.prdata = {23'h0, c};
        `AFS_DELAY_OFS:  st_next.prdata = st_reg.delay;
        `AFS_STATUS_OFS: st_next.prdata = {17'h0, st_reg.all_lost, st_reg.disc_stop, st_reg.net_stop,
                                           st_reg.power_on, st_reg.wdog, st_reg.rail, st_reg.nvfail,
                                           st_reg.feedback, st_reg.tsens, st_reg.limp, st_reg.derate,
                                           st_reg.overtemp, st_reg.claim, st_reg.bus_err, st_reg.missing};
        `AFS_ACTION_OFS: st_next.prdata = {26'h0, st_reg.shut, st_reg.alarm, st_reg.drive};
        `AFS_DEMAND_OFS: st_next.prdata = {16'h0, st_reg.demand_held};
        `AFS_TEMP_OFS:   st_next.prdata = {23'h0, st_reg.temp_used};
        default:         st_next.prdata = 32'h0;
      endcase
      st_next.pslverr = i_apb.paddr > `AFS_TEMP_OFS || i_apb.paddr[1:0] != 2'h0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Power-on flag comes up set after every reset release
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg          <= '0;
      st_reg.power_on <= 1'b1;
      st_reg.drive    <= AFS_DRV_LIMP;
      st_reg.cfg      <= 32'h0000_03F1;
      st_reg.delay    <= 32'h0100_0100;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_apb             = '{st_reg.pready, st_reg.pslverr, st_reg.prdata};
  assign o_net_demand      = st_reg.demand_held;
  assign o_drive           = st_reg.drive;
  assign o_current_derate  = st_reg.derate;
  assign o_alarm           = st_reg.alarm;
  assign o_shutdown        = st_reg.shut;
  assign o_stop_indication = st_reg.stop_ind;
endmodule // afs_supervisor

// ### afs_supervisor_props.sv
module afs_supervisor_props
  import afs_pkg::*;
#(
  parameter int unsigned FEEDBACK_CYC = 10,
  parameter int unsigned THERMAL_CYC  = 20
) (
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  input wire afs_apb_req_t       i_apb,
  input wire afs_apb_rsp_t       o_apb,
  input wire logic               i_demand_strobe,
  input wire logic [15:0]        i_demand_value,
  input wire logic               i_bus_passive,
  input wire logic               i_claim_fail,
  input wire logic               i_name_change,
  input wire logic               i_nv_bad,
  input wire logic               i_feedback_bad,
  input wire logic signed [8:0]  i_temp_a,
  input wire logic signed [8:0]  i_temp_b,
  input wire logic [15:0]        o_net_demand,
  input wire afs_drive_t         o_drive,
  input wire logic               o_current_derate,
  input wire logic               o_alarm,
  input wire logic               o_shutdown,
  input wire logic               o_stop_indication
);
  // Run lengths of the causes; 16 bits outlast the whole run
  logic [15:0] fb_cnt;
  logic [15:0] hot_cnt;
  logic [15:0] split_cnt;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fb_cnt    <= 16'h0000;
      hot_cnt   <= 16'h0000;
      split_cnt <= 16'h0000;
    end else begin
      fb_cnt    <= i_feedback_bad ? fb_cnt + 16'h0001 : 16'h0000;
      hot_cnt   <= (i_temp_a > 9'sd140 && i_temp_b > 9'sd140) ? hot_cnt + 16'h0001 : 16'h0000;
      split_cnt <= (i_temp_a > 9'sd140 && i_temp_b < -9'sd45) ? split_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ************************************************
  // Properties; slack of 8 covers the input synchronisers
  // ************************************************
  // Claim is only retried after a name change, so the fault needs that retry first
  a_claim_zero: assert property (i_name_change [*3] ##1 (!i_name_change && i_claim_fail) [*8] |-> o_net_demand == 16'h0000)
    else $error("demand not forced to zero on claim failure");
  a_bad_hold: assert property (i_demand_strobe && i_demand_value >= 16'hFB00 |=> $stable(o_net_demand) [*3])
    else $error("demand moved on an out of range value");
  a_passive_hold: assert property (i_bus_passive [*8] ##0 i_demand_strobe |=> $stable(o_net_demand) [*2])
    else $error("demand moved while bus error passive");
  a_stop_common: assert property (o_stop_indication [*3] |-> o_alarm || o_shutdown)
    else $error("stop without common alarm or shutdown");
  a_nv_limp: assert property (i_nv_bad [*8] |-> o_drive == AFS_DRV_LIMP)
    else $error("bad stored data did not go limp");
  a_fb_limp: assert property (fb_cnt > FEEDBACK_CYC + 8 |-> o_drive == AFS_DRV_LIMP)
    else $error("feedback failure did not cut current");
  a_hot_limp: assert property (hot_cnt > THERMAL_CYC + 8 |-> o_drive == AFS_DRV_LIMP)
    else $error("overheated drive not limp");
  a_split_cool: assert property (split_cnt > 2 * THERMAL_CYC + 8 |-> !o_current_derate)
    else $error("failed sensors not replaced by default temperature");
  a_derate_cause: assert property ($rose(o_current_derate) |-> $past(i_temp_a) > 9'sd100 || $past(i_temp_b) > 9'sd100)
    else $error("derate raised without high temperature");
  a_ready_pulse: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready ##1 !o_apb.pready)
    else $error("pready not a single access cycle pulse");
  c_derate: cover property ($rose(o_current_derate));
  c_limp: cover property (o_drive == AFS_DRV_LIMP);
  c_slverr: cover property (o_apb.pslverr);
endmodule // afs_supervisor_props

bind afs_supervisor afs_supervisor_props #(.FEEDBACK_CYC(FEEDBACK_CYC), .THERMAL_CYC(THERMAL_CYC)) afs_props_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(i_apb), .o_apb(o_apb), .i_demand_strobe(i_demand_strobe),
  .i_demand_value(i_demand_value), .i_bus_passive(i_bus_passive), .i_claim_fail(i_claim_fail),
  .i_name_change(i_name_change),
  .i_nv_bad(i_nv_bad), .i_feedback_bad(i_feedback_bad), .i_temp_a(i_temp_a), .i_temp_b(i_temp_b),
  .o_net_demand(o_net_demand), .o_drive(o_drive), .o_current_derate(o_current_derate), .o_alarm(o_alarm),
  .o_shutdown(o_shutdown), .o_stop_indication(o_stop_indication));

// ### afs_host_model.sv
module afs_host_model (
  input  wire logic  i_clk,
  output logic       o_demand_strobe,
  output logic [15:0] o_demand_value
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines
  initial begin
    o_demand_strobe = 1'b0;
    o_demand_value  = 16'h0000;
  end
  // One demand frame; between frames the value shows the inverse, so stale data is never mistaken
  task automatic send(input logic [15:0] v);
    @(posedge i_clk);
    o_demand_strobe <= 1'b1;
    o_demand_value  <= v;
    @(posedge i_clk);
    o_demand_strobe <= 1'b0;
    o_demand_value  <= ~v;
  endtask
endmodule // afs_host_model

// ### afs_supervisor_tb_top.sv
`include "afs_params.svh"
module afs_supervisor_tb_top
  import afs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run brief
  localparam int unsigned FB_CYC = 10;
  localparam int unsigned RAIL_N = 10;
  localparam int unsigned TH_CYC = 20;
  logic              clk, rst_b, reset_cmd, bus_passive, claim_fail, name_change, disc_run, net_stop;
  logic [3:0]        lat_in;
  logic signed [8:0] temp_a, temp_b;
  logic              dstb, derate, alarm, shut, stop_ind, rerr;
  logic [15:0]       dval, net_dmd;
  logic [31:0]       rdat;
  afs_apb_req_t      apb_req;
  afs_apb_rsp_t      apb_rsp;
  afs_drive_t        drv;
  int                err_count = 0;
  int                n_checks = 0;
  int                cyc = 0;
  afs_supervisor #(.FEEDBACK_CYC(FB_CYC), .RAIL_CYC(RAIL_N), .THERMAL_CYC(TH_CYC)) afs_supervisor_inst (
    .i_clk(clk), .i_rst_b(rst_b), .i_apb(apb_req), .o_apb(apb_rsp), .i_demand_strobe(dstb),
    .i_demand_value(dval), .i_bus_passive(bus_passive), .i_claim_fail(claim_fail), .i_name_change(name_change),
    .i_discrete_run(disc_run), .i_net_stop_cmd(net_stop), .i_reset_cmd(reset_cmd), .i_temp_a(temp_a),
    .i_temp_b(temp_b), .i_feedback_bad(lat_in[0]), .i_nv_bad(lat_in[1]), .i_rail_bad(lat_in[2]),
    .i_wd_reset(lat_in[3]), .o_net_demand(net_dmd), .o_drive(drv), .o_current_derate(derate),
    .o_alarm(alarm), .o_shutdown(shut), .o_stop_indication(stop_ind));
  afs_host_model afs_host_model_inst (.i_clk(clk), .o_demand_strobe(dstb), .o_demand_value(dval));
  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // APB transfer; request held until pready is seen high at a rising edge, data taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic st(input int b, input logic e);
    apb(1'b0, `AFS_STATUS_OFS, 32'h0);
    check("status bit", {31'h0, rdat[b]}, {31'h0, e});
  endtask
  task automatic rcmd;
    @(posedge clk);
    reset_cmd <= 1'b1;
    @(posedge clk);
    reset_cmd <= 1'b0;
    wait_cyc(3);
  endtask
  // Pulse one latching cause, then see it latch or not, and clear by command
  task automatic lat_case(input int idx, input int n, input int sb, input logic e, input logic lmp);
    @(posedge clk);
    lat_in[idx] <= 1'b1;
    wait_cyc(n);
    lat_in[idx] <= 1'b0;
    wait_cyc(8);
    st(sb, e);
    if (lmp) check("drive", 32'(drv), 32'(AFS_DRV_LIMP));
    rcmd;
    st(sb, 1'b0);
  endtask
  task automatic settemp(input logic signed [8:0] a, input logic signed [8:0] b, input int n);
    temp_a <= a;
    temp_b <= b;
    wait_cyc(n);
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard; the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    rst_b = 1'b0;
    apb_req = '0;
    {reset_cmd, bus_passive, claim_fail, name_change, net_stop} = 5'h00;
    disc_run = 1'b1;
    lat_in = 4'h0;
    temp_a = 9'sd25;
    temp_b = 9'sd25;
    wait_cyc(20);
    rst_b <= 1'b1;
    st(11, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", {31'h0, rerr}, 32'h1);
    check("unmapped data", rdat, 32'h0);
    rcmd;
    st(11, 1'b0);
    apb(1'b1, `AFS_DELAY_OFS, 32'hFFFF_FFFF);
    apb(1'b1, `AFS_CFG_OFS, 32'h0000_03F5);
    afs_host_model_inst.send(16'h1234);
    wait_cyc(4);
    check("demand", {16'h0, net_dmd}, 32'h1234);
    bus_passive <= 1'b1;
    wait_cyc(8);
    st(1, 1'b1);
    afs_host_model_inst.send(16'h2222);
    wait_cyc(4);
    check("demand passive", {16'h0, net_dmd}, 32'h1234);
    bus_passive <= 1'b0;
    wait_cyc(8);
    st(1, 1'b0);
    afs_host_model_inst.send(16'hFAFF);
    wait_cyc(4);
    check("demand edge", {16'h0, net_dmd}, 32'hFAFF);
    afs_host_model_inst.send(16'hFB00);
    wait_cyc(4);
    check("demand bad", {16'h0, net_dmd}, 32'hFAFF);
    st(0, 1'b1);
    claim_fail <= 1'b1;
    name_change <= 1'b1;
    wait_cyc(6);
    name_change <= 1'b0;
    wait_cyc(8);
    check("demand claim", {16'h0, net_dmd}, 32'h0);
    claim_fail <= 1'b0;
    wait_cyc(8);
    st(2, 1'b1);
    name_change <= 1'b1;
    wait_cyc(6);
    name_change <= 1'b0;
    wait_cyc(8);
    st(2, 1'b0);
    apb(1'b1, `AFS_CFG_OFS, 32'h0000_83F1);
    disc_run <= 1'b0;
    wait_cyc(8);
    check("stop ind", {31'h0, stop_ind}, 32'h1);
    check("common out", {31'h0, alarm | shut}, 32'h1);
    check("stop drive", 32'(drv), 32'(AFS_DRV_LIMP));
    disc_run <= 1'b1;
    wait_cyc(8);
    check("stop ind off", {31'h0, stop_ind}, 32'h0);
    lat_case(0, 5, 7, 1'b0, 1'b0);
    lat_case(0, 30, 7, 1'b1, 1'b1);
    lat_case(1, 10, 8, 1'b1, 1'b1);
    lat_case(2, 5, 9, 1'b0, 1'b0);
    lat_case(2, 30, 9, 1'b1, 1'b0);
    lat_case(3, 6, 10, 1'b1, 1'b0);
    settemp(9'sd120, 9'sd120, 40);
    check("derate", {31'h0, derate}, 32'h1);
    settemp(9'sd150, 9'sd150, 40);
    check("hot drive", 32'(drv), 32'(AFS_DRV_LIMP));
    settemp(9'sd30, 9'sd30, 90);
    check("derate off", {31'h0, derate}, 32'h0);
    check("cool drive", 32'(drv), 32'(AFS_DRV_RUN));
    settemp(9'sd150, -9'sd50, 60);
    st(6, 1'b1);
    check("split derate", {31'h0, derate}, 32'h0);
    settemp(9'sd25, 9'sd25, 4);
    stop_test;
  end
endmodule // afs_supervisor_tb_top
